// ===== core/ssm_pkg.sv
// Shared constants and types for the synchronous serial master
package ssm_pkg;

	// Register byte addresses, one aligned word each
	localparam int          ADDR_W       = 6;
	localparam logic [5:0]  OFS_FLAGS    = 6'h00;
	localparam logic [5:0]  OFS_ENABLES  = 6'h04;
	localparam logic [5:0]  OFS_PRIORITY = 6'h08;
	localparam logic [5:0]  OFS_RX_STAT  = 6'h0C;
	localparam logic [5:0]  OFS_TX_HOLD  = 6'h10;
	localparam logic [5:0]  OFS_TX_STAT  = 6'h14;
	localparam logic [5:0]  OFS_BAUD_CTL = 6'h18;
	localparam logic [5:0]  OFS_DIV_HI   = 6'h1C;
	localparam logic [5:0]  OFS_DIV_LO   = 6'h20;
	localparam logic [5:0]  OFS_RX_BUF   = 6'h24;
	localparam logic [5:0]  OFS_IRQ_CTL  = 6'h28;

	// Field positions
	localparam int BIT_TX_FLAG     = 4;
	localparam int BIT_RX_FLAG     = 5;
	localparam int BIT_TX_IE       = 4;
	localparam int BIT_RX_IE       = 5;
	localparam int BIT_CLK_SRC     = 7;
	localparam int BIT_TX_NINE     = 6;
	localparam int BIT_TX_EN       = 5;
	localparam int BIT_SYNC        = 4;
	localparam int BIT_SHIFT_EMPTY = 1;
	localparam int BIT_TX_NINTH    = 0;
	localparam int BIT_PORT_EN     = 7;
	localparam int BIT_RX_NINE     = 6;
	localparam int BIT_SINGLE_RX   = 5;
	localparam int BIT_CONT_RX     = 4;
	localparam int BIT_OVERRUN     = 1;
	localparam int BIT_RX_NINTH    = 0;
	localparam int BIT_RX_IDLE     = 6;
	localparam int BIT_DATA_POL    = 5;
	localparam int BIT_CLK_POL     = 4;
	localparam int BIT_WIDE_DIV    = 3;
	localparam int BIT_GLOBAL_IE   = 7;
	localparam int BIT_PERIPH_IE   = 6;

	// Reset values and word lengths
	localparam logic [7:0]  RESET_BYTE = 8'h00;
	localparam logic [3:0]  BITS_EIGHT = 4'h8;
	localparam logic [3:0]  BITS_NINE  = 4'h9;

	// Software-programmed control bits
	typedef struct packed {
		logic       clk_src;
		logic       tx_nine;
		logic       tx_en;
		logic       sync_mode;
		logic       tx_ninth;
		logic       port_en;
		logic       rx_nine;
		logic       single_rx;
		logic       cont_rx;
		logic       data_pol;
		logic       clk_pol;
		logic       wide_div;
		logic       tx_ie;
		logic       rx_ie;
		logic       global_ie;
		logic       periph_ie;
		logic [7:0] priority_bits;
		logic [7:0] div_hi;
		logic [7:0] div_lo;
	} ssm_cfg_t;

	// Shift engine states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TX_LOAD,
		ST_TX_SHIFT,
		ST_RX_SHIFT
	} ssm_state_t;

endpackage

// ===== core/ssm_sync2.sv
// Two-flop synchroniser for a pin input
`timescale 1ns/1ps
module ssm_sync2 (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_reg;

	// First flop feeds only the second
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // ssm_sync2

// ===== core/ssm_baud_gen.sv
// Divisor-driven tick generator for the shift clock
`timescale 1ns/1ps
module ssm_baud_gen (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        run_in,
	input  wire logic        wide_in,
	input  wire logic [15:0] divisor_in,
	output logic             tick_out
);
	logic [15:0] count_reg;
	logic [15:0] limit;

	// Narrow mode uses the low byte only
	assign limit = wide_in ? divisor_in : {8'h00, divisor_in[7:0]};

	// Tick every limit+1 clocks; idle preloads one spent clock so the
	// registered tick does not stretch the first half-bit of a word
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_reg <= 16'h0000;
			tick_out  <= 1'b0;
		end else if (!run_in) begin
			count_reg <= 16'h0001;
			tick_out  <= (limit == 16'h0000);
		end else if (count_reg >= limit) begin
			count_reg <= 16'h0000;
			tick_out  <= 1'b1;
		end else begin
			count_reg <= count_reg + 16'h0001;
			tick_out  <= 1'b0;
		end
	end
endmodule // ssm_baud_gen

// ===== core/ssm_master.sv
// Synchronous serial master: registers, shift engine and pins
//
// How it works
// - Reload shift register only after last bit
// - One-cycle transfer empties buffer, sets flag
// - Transmit flag ignores enable; enable gates request
// - Only holding-buffer writes clear transmit flag
// - Read-only shift-empty status, no interrupt
// - Shift register has no register address
// - Polarity bits invert clock and data pins
// - Nine-bit mode shifts out the ninth bit
// - Either receive enable starts reception
// - Receive data sampled at clock return edge
// - Single enable receives one word, stops
// - Continuous enable keeps receiving until cleared
// - Continuous wins when both enables set
// - Receive flag on completion; enable gates request
// - Status holds ninth bit, overrun; buffer data
// - Clearing continuous enable clears latched error
// - Half-duplex: one direction at a time
// - Master drives the shift clock line
// - Polarity bits set idle line levels
`timescale 1ns/1ps
module ssm_master
	import ssm_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              reset_n_in,
	input  wire logic [ADDR_W-1:0] avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic [31:0]            avs_readdata_out,
	output logic                   avs_waitrequest_out,
	output logic                   irq_request_out,
	output logic                   shift_clock_line_out,
	output logic                   shift_clock_line_oe_out,
	input  wire logic              serial_data_line_in,
	output logic                   serial_data_line_out,
	output logic                   serial_data_line_oe_out
);
	ssm_cfg_t   cfg_reg;
	ssm_state_t state_reg;
	logic       ack_reg;
	logic       wr_go;
	logic       rd_go;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;
	logic [7:0] hold_reg;
	logic       hold_full_reg;
	logic [8:0] transmit_shift_reg;
	logic [8:0] rx_shift_reg;
	logic [8:0] rx_nxt;
	logic [7:0] rx_buf_reg;
	logic       rx_ninth_reg;
	logic       rx_flag_reg;
	logic       overrun_reg;
	logic [3:0] bit_cnt_reg;
	logic [3:0] word_bits;
	logic       phase_reg;
	logic       tick;
	logic       data_sync;
	logic       port_ok;
	logic       rx_req;
	logic       shifting;
	logic       bit_end;
	logic       word_end;
	logic       rx_done;
	logic       single_done;
	logic       tx_flag;

	// Bus handshake: one wait cycle, then the request is taken
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_reg;
	assign wr_go = avs_write_in & ack_reg & avs_byteenable_in[0];
	assign rd_go = avs_read_in & ack_reg;
	assign wbyte = avs_writedata_in[7:0];

	// Port usable only as an enabled synchronous master
	assign port_ok  = cfg_reg.port_en & cfg_reg.sync_mode & cfg_reg.clk_src;
	assign rx_req   = cfg_reg.single_rx | cfg_reg.cont_rx;
	assign shifting = (state_reg == ST_TX_SHIFT) |
	                  (state_reg == ST_RX_SHIFT);
	assign tx_flag  = ~hold_full_reg;

	// Word length and bit boundaries
	assign word_bits = (state_reg == ST_RX_SHIFT) ?
	                   (cfg_reg.rx_nine ? BITS_NINE : BITS_EIGHT) :
	                   (cfg_reg.tx_nine ? BITS_NINE : BITS_EIGHT);
	assign bit_end  = shifting & tick & phase_reg;
	assign word_end = bit_end & (bit_cnt_reg == word_bits - 4'h1);
	assign rx_done  = word_end & (state_reg == ST_RX_SHIFT);
	// Hardware drops the single request unless continuous overrides
	assign single_done = rx_done & ~cfg_reg.cont_rx;

	// Bit assembled from the synchronised, polarity-corrected pin
	assign rx_nxt = {data_sync ^ cfg_reg.data_pol, rx_shift_reg[8:1]};

	ssm_sync2 u_data_sync (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.async_in   (serial_data_line_in),
		.sync_out   (data_sync)
	);

	// Half-bit ticks; counter restarts at each transmitted word, not between continuous receive words
	ssm_baud_gen u_baud (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.run_in     (shifting),
		.wide_in    (cfg_reg.wide_div),
		.divisor_in ({cfg_reg.div_hi, cfg_reg.div_lo}),
		.tick_out   (tick)
	);

	// Acknowledge toggles so every request waits exactly one cycle
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
		end
	end

	// Read mux; the shift register has no address at all
	always_comb begin
		rd_byte = RESET_BYTE;
		if (avs_address_in == OFS_FLAGS) begin
			rd_byte[BIT_RX_FLAG] = rx_flag_reg;
			rd_byte[BIT_TX_FLAG] = tx_flag;
		end else if (avs_address_in == OFS_ENABLES) begin
			rd_byte[BIT_RX_IE] = cfg_reg.rx_ie;
			rd_byte[BIT_TX_IE] = cfg_reg.tx_ie;
		end else if (avs_address_in == OFS_PRIORITY) begin
			rd_byte = cfg_reg.priority_bits;
		end else if (avs_address_in == OFS_RX_STAT) begin
			rd_byte[BIT_PORT_EN]   = cfg_reg.port_en;
			rd_byte[BIT_RX_NINE]   = cfg_reg.rx_nine;
			rd_byte[BIT_SINGLE_RX] = cfg_reg.single_rx;
			rd_byte[BIT_CONT_RX]   = cfg_reg.cont_rx;
			rd_byte[BIT_OVERRUN]   = overrun_reg;
			rd_byte[BIT_RX_NINTH]  = rx_ninth_reg;
		end else if (avs_address_in == OFS_TX_HOLD) begin
			rd_byte = hold_reg;
		end else if (avs_address_in == OFS_TX_STAT) begin
			rd_byte[BIT_CLK_SRC]     = cfg_reg.clk_src;
			rd_byte[BIT_TX_NINE]     = cfg_reg.tx_nine;
			rd_byte[BIT_TX_EN]       = cfg_reg.tx_en;
			rd_byte[BIT_SYNC]        = cfg_reg.sync_mode;
			rd_byte[BIT_SHIFT_EMPTY] = ~((state_reg == ST_TX_SHIFT) |
			                   (state_reg == ST_TX_LOAD));
			rd_byte[BIT_TX_NINTH]    = cfg_reg.tx_ninth;
		end else if (avs_address_in == OFS_BAUD_CTL) begin
			rd_byte[BIT_RX_IDLE]  = (state_reg != ST_RX_SHIFT);
			rd_byte[BIT_DATA_POL] = cfg_reg.data_pol;
			rd_byte[BIT_CLK_POL]  = cfg_reg.clk_pol;
			rd_byte[BIT_WIDE_DIV] = cfg_reg.wide_div;
		end else if (avs_address_in == OFS_DIV_HI) begin
			rd_byte = cfg_reg.div_hi;
		end else if (avs_address_in == OFS_DIV_LO) begin
			rd_byte = cfg_reg.div_lo;
		end else if (avs_address_in == OFS_RX_BUF) begin
			rd_byte = rx_buf_reg;
		end else if (avs_address_in == OFS_IRQ_CTL) begin
			rd_byte[BIT_GLOBAL_IE] = cfg_reg.global_ie;
			rd_byte[BIT_PERIPH_IE] = cfg_reg.periph_ie;
		end
	end

	// Read data captured in the wait cycle, stands at the taking edge
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in & ~ack_reg) begin
			avs_readdata_out <= {24'h00_0000, rd_byte};
		end
	end

	// Control bits; flag register writes are ignored entirely
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg_reg <= '0;
		end else begin
			if (wr_go && avs_address_in == OFS_ENABLES) begin
				cfg_reg.rx_ie <= wbyte[BIT_RX_IE];
				cfg_reg.tx_ie <= wbyte[BIT_TX_IE];
			end else if (wr_go && avs_address_in == OFS_PRIORITY) begin
				cfg_reg.priority_bits <= wbyte;
			end else if (wr_go && avs_address_in == OFS_RX_STAT) begin
				cfg_reg.port_en   <= wbyte[BIT_PORT_EN];
				cfg_reg.rx_nine   <= wbyte[BIT_RX_NINE];
				cfg_reg.single_rx <= wbyte[BIT_SINGLE_RX];
				cfg_reg.cont_rx   <= wbyte[BIT_CONT_RX];
			end else if (wr_go && avs_address_in == OFS_TX_STAT) begin
				cfg_reg.clk_src   <= wbyte[BIT_CLK_SRC];
				cfg_reg.tx_nine   <= wbyte[BIT_TX_NINE];
				cfg_reg.tx_en     <= wbyte[BIT_TX_EN];
				cfg_reg.sync_mode <= wbyte[BIT_SYNC];
				cfg_reg.tx_ninth  <= wbyte[BIT_TX_NINTH];
			end else if (wr_go && avs_address_in == OFS_BAUD_CTL) begin
				cfg_reg.data_pol <= wbyte[BIT_DATA_POL];
				cfg_reg.clk_pol  <= wbyte[BIT_CLK_POL];
				cfg_reg.wide_div <= wbyte[BIT_WIDE_DIV];
			end else if (wr_go && avs_address_in == OFS_DIV_HI) begin
				cfg_reg.div_hi <= wbyte;
			end else if (wr_go && avs_address_in == OFS_DIV_LO) begin
				cfg_reg.div_lo <= wbyte;
			end else if (wr_go && avs_address_in == OFS_IRQ_CTL) begin
				cfg_reg.global_ie <= wbyte[BIT_GLOBAL_IE];
				cfg_reg.periph_ie <= wbyte[BIT_PERIPH_IE];
			end
			// Hardware clear of the single request wins over a write
			if (single_done) begin
				cfg_reg.single_rx <= 1'b0;
			end
		end
	end

	// Holding buffer; a write marks it full and drops the flag
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hold_reg      <= RESET_BYTE;
			hold_full_reg <= 1'b0;
		end else if (wr_go && avs_address_in == OFS_TX_HOLD) begin
			hold_reg      <= wbyte;
			hold_full_reg <= 1'b1;
		end else if (state_reg == ST_TX_LOAD) begin
			hold_full_reg <= 1'b0;
		end
	end

	// Shift engine; one direction at a time
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= ST_IDLE;
		end else if (!port_ok) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				// Receive requests take the line first when idle
				if (rx_req) begin
					state_reg <= ST_RX_SHIFT;
				end else if (cfg_reg.tx_en && hold_full_reg) begin
					state_reg <= ST_TX_LOAD;
				end
			end
			ST_TX_LOAD: begin
				state_reg <= ST_TX_SHIFT;
			end
			ST_TX_SHIFT: begin
				if (!cfg_reg.tx_en) begin
					state_reg <= ST_IDLE;
				end else if (word_end) begin
					// Next word only once the last bit is out
					state_reg <= hold_full_reg ? ST_TX_LOAD
					                           : ST_IDLE;
				end
			end
			ST_RX_SHIFT: begin
				if (!rx_req) begin
					state_reg <= ST_IDLE;
				end else if (rx_done && !cfg_reg.cont_rx) begin
					state_reg <= ST_IDLE;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// Bit counter and half-bit phase; phase 0 is the active half
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bit_cnt_reg <= 4'h0;
			phase_reg   <= 1'b0;
		end else if (!shifting) begin
			bit_cnt_reg <= 4'h0;
			phase_reg   <= 1'b0;
		end else if (tick) begin
			phase_reg <= ~phase_reg;
			if (word_end) begin
				bit_cnt_reg <= 4'h0;
			end else if (phase_reg) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// Transmit shift register, LSB first, ninth bit on top
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			transmit_shift_reg <= 9'h000;
		end else if (state_reg == ST_TX_LOAD) begin
			transmit_shift_reg <= {cfg_reg.tx_ninth, hold_reg};
		end else if (bit_end && state_reg == ST_TX_SHIFT) begin
			transmit_shift_reg <= {1'b0, transmit_shift_reg[8:1]};
		end
	end

	// Sample as the clock returns to idle, end of the active half
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_shift_reg <= 9'h000;
		end else if (state_reg != ST_RX_SHIFT) begin
			rx_shift_reg <= 9'h000;
		end else if (tick && !phase_reg) begin
			rx_shift_reg <= rx_nxt;
		end
	end

	// Received word, ninth bit and overrun
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_buf_reg   <= RESET_BYTE;
			rx_ninth_reg <= 1'b0;
			overrun_reg  <= 1'b0;
		end else begin
			if (wr_go && avs_address_in == OFS_RX_STAT &&
			    !wbyte[BIT_CONT_RX]) begin
				overrun_reg <= 1'b0;
			end
			// An unread word is kept; the new one is dropped
			if (rx_done && rx_flag_reg) begin
				overrun_reg <= 1'b1;
			end else if (rx_done) begin
				rx_buf_reg   <= cfg_reg.rx_nine ? rx_shift_reg[7:0]
				                                : rx_shift_reg[8:1];
				rx_ninth_reg <= cfg_reg.rx_nine & rx_shift_reg[8];
			end
		end
	end

	// Receive flag: set by a completed word, cleared by buffer read
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_flag_reg <= 1'b0;
		end else if (rx_done) begin
			rx_flag_reg <= 1'b1;
		end else if (rd_go && avs_address_in == OFS_RX_BUF) begin
			rx_flag_reg <= 1'b0;
		end
	end

	// Request gated by enables; flags themselves are never gated
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_request_out <= 1'b0;
		end else begin
			irq_request_out <= cfg_reg.global_ie & cfg_reg.periph_ie &
			                   ((tx_flag & cfg_reg.tx_ie) |
			                    (rx_flag_reg & cfg_reg.rx_ie));
		end
	end

	// Pin drive; idle levels follow the polarity bits
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shift_clock_line_out    <= 1'b0;
			shift_clock_line_oe_out <= 1'b0;
			serial_data_line_out    <= 1'b0;
			serial_data_line_oe_out <= 1'b0;
		end else begin
			shift_clock_line_oe_out <= port_ok;
			shift_clock_line_out    <= (shifting & ~phase_reg) ^
			                           cfg_reg.clk_pol;
			serial_data_line_out    <=
				((state_reg == ST_TX_SHIFT) & transmit_shift_reg[0]) ^
				cfg_reg.data_pol;
			// Data line released while receiving
			serial_data_line_oe_out <= port_ok & cfg_reg.tx_en &
			                           (state_reg != ST_RX_SHIFT);
		end
	end
endmodule // ssm_master

// ===== bench/ssm_master_monitor.sv
// Port-level assertions for the synchronous serial master
`timescale 1ns/1ps
module ssm_master_monitor
	import ssm_pkg::*;
(
	input wire logic              clk_in,
	input wire logic              reset_n_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic              avs_read_in,
	input wire logic              avs_write_in,
	input wire logic [31:0]       avs_writedata_in,
	input wire logic [31:0]       avs_readdata_out,
	input wire logic              avs_waitrequest_out,
	input wire logic              irq_request_out,
	input wire logic              shift_clock_line_out,
	input wire logic              shift_clock_line_oe_out,
	input wire logic              serial_data_line_out,
	input wire logic              serial_data_line_oe_out
);
	logic       pol_reg, txok_reg, rxok_reg, ien_reg, gie_reg;
	logic [7:0] div_reg, act_reg, quiet_reg, wd;
	logic       req, wr, ok, idle_now;
	assign req      = avs_read_in | avs_write_in;
	assign wr       = avs_write_in & ~avs_waitrequest_out;
	assign wd       = avs_writedata_in[7:0];
	assign ok       = txok_reg & rxok_reg;
	assign idle_now = shift_clock_line_out == pol_reg;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// Config shadow, fed by taken writes only
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pol_reg  <= 1'b0;
			txok_reg <= 1'b0;
			rxok_reg <= 1'b0;
			ien_reg  <= 1'b0;
			gie_reg  <= 1'b0;
			div_reg  <= 8'h00;
		end else if (wr) begin
			case (avs_address_in)
				OFS_BAUD_CTL: pol_reg  <= wd[BIT_CLK_POL];
				OFS_TX_STAT:  txok_reg <= wd[BIT_CLK_SRC] & wd[BIT_SYNC];
				OFS_RX_STAT:  rxok_reg <= wd[BIT_PORT_EN];
				OFS_ENABLES:  ien_reg  <= wd[BIT_TX_IE] | wd[BIT_RX_IE];
				OFS_IRQ_CTL:  gie_reg  <= wd[BIT_GLOBAL_IE] & wd[BIT_PERIPH_IE];
				OFS_DIV_LO:   div_reg  <= wd;
				default: ;
			endcase
		end
	end
	// Active-half length; receive writes may abort a half, so skip those
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			act_reg   <= 8'h00;
			quiet_reg <= 8'h00;
		end else begin
			act_reg <= idle_now ? 8'h00 : act_reg + 8'h01;
			if (wr && avs_address_in == OFS_RX_STAT)
				quiet_reg <= 8'h00;
			else if (quiet_reg != 8'hFF)
				quiet_reg <= quiet_reg + 8'h01;
		end
	end
	chk_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
		else $error("request not held off");
	chk_wait_once: assert property (req && avs_waitrequest_out |=>
		!avs_waitrequest_out) else $error("wait lasted over one cycle");
	chk_wait_idle: assert property (!req |-> !avs_waitrequest_out)
		else $error("wait without request");
	chk_rd_upper: assert property (avs_readdata_out[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	chk_clk_oe_follow: assert property (
		ok == $past(ok) && ok == $past(ok, 2) |->
		shift_clock_line_oe_out == ok) else $error("clock drive wrong");
	chk_half_len: assert property (
		idle_now && !$past(idle_now) && pol_reg == $past(pol_reg, 3) &&
		quiet_reg > 8'h10 |-> act_reg == div_reg + 8'h01)
		else $error("active half length wrong");
	chk_data_stable: assert property (
		serial_data_line_oe_out && !idle_now && !$past(idle_now) |->
		$stable(serial_data_line_out)) else $error("data moved in bit");
	chk_irq_gate: assert property (
		irq_request_out |-> (gie_reg && ien_reg) || $past(gie_reg && ien_reg))
		else $error("request while gated off");
	cover property (irq_request_out);
	cover property ($rose(serial_data_line_oe_out));
	cover property (idle_now && !$past(idle_now));
endmodule // ssm_master_monitor

// ===== bench/ssm_slave_model.sv
// Far-side slave: takes and gives words on the link
`timescale 1ns/1ps
module ssm_slave_model (
	input  wire logic       clk_in,
	input  wire logic       ck_in,
	input  wire logic       dt_in,
	input  wire logic       ck_pol_in,
	input  wire logic       dt_pol_in,
	input  wire logic       nine_in,
	input  wire logic       clr_in,
	input  wire logic [8:0] word_in,
	output logic            dt_out,
	output logic [8:0]      got_out,
	output logic [7:0]      cnt_out
);
	logic [8:0] sh_reg, full;
	logic [3:0] idx_reg, last;
	logic       ck_last, back;
	initial begin
		sh_reg  = 9'h000;
		idx_reg = 4'h0;
		ck_last = 1'b0;
		got_out = 9'h000;
		cnt_out = 8'h00;
	end
	assign back = ck_in == ck_pol_in && ck_last != ck_pol_in;
	assign full = {dt_in ^ dt_pol_in, sh_reg[8:1]};
	assign last = nine_in ? 4'h8 : 4'h7;
	// Next bit driven two clocks after the master's sample, once the clock is back at idle
	assign dt_out = word_in[idx_reg] ^ dt_pol_in;
	// Move one bit per return of the clock to idle, lsb first
	always @(posedge clk_in) begin
		ck_last <= ck_in;
		if (clr_in)
			idx_reg <= 4'h0;
		else if (back) begin
			sh_reg <= full;
			if (idx_reg == last) begin
				idx_reg <= 4'h0;
				got_out <= nine_in ? full : {1'b0, full[8:1]};
				cnt_out <= cnt_out + 8'h01;
			end else
				idx_reg <= idx_reg + 4'h1;
		end
	end
endmodule // ssm_slave_model

// ===== bench/ssm_master_tb_top.sv
// Register-level bench for the synchronous serial master
`timescale 1ns/1ps
module ssm_master_tb_top import ssm_pkg::*;;
	logic              clk_in = 1'b0, reset_n_in = 1'b0;
	logic              avs_read_in = 1'b0, avs_write_in = 1'b0;
	logic [ADDR_W-1:0] avs_address_in = '0;
	logic [31:0]       avs_writedata_in = 32'h0000_0000;
	logic [3:0]        avs_byteenable_in = 4'h1;
	logic [31:0]       avs_readdata_out;
	logic              avs_waitrequest_out, irq_request_out, mdl_dt;
	logic              shift_clock_line_out, shift_clock_line_oe_out;
	logic              serial_data_line_in, serial_data_line_out;
	logic              serial_data_line_oe_out;
	logic              mpol = 1'b0, mdpol = 1'b0, mnine = 1'b0, mclr = 1'b0;
	logic [8:0]        mword = 9'h000, got;
	logic [7:0]        gcnt, rd;
	int                fail_count = 0, checks_done = 0;
	// Wire level: whoever has the drive sets it
	assign serial_data_line_in = serial_data_line_oe_out ?
		serial_data_line_out : mdl_dt;
	always #5 clk_in = ~clk_in;
	ssm_master DUT (
		.clk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .irq_request_out, .shift_clock_line_out,
		.shift_clock_line_oe_out, .serial_data_line_in,
		.serial_data_line_out, .serial_data_line_oe_out
	);
	ssm_slave_model u_slave (
		.clk_in, .ck_in(shift_clock_line_out), .dt_in(serial_data_line_in),
		.ck_pol_in(mpol), .dt_pol_in(mdpol), .nine_in(mnine), .clr_in(mclr),
		.word_in(mword), .dt_out(mdl_dt), .got_out(got), .cnt_out(gcnt)
	);
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// One bus cycle, held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [7:0] d);
		int n;
		@(posedge clk_in);
		avs_address_in   <= a;
		avs_writedata_in <= {24'h00_0000, d};
		avs_write_in     <= w;
		avs_read_in      <= !w;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 50);
		rd = avs_readdata_out[7:0];
		avs_read_in  <= 1'b0;
		avs_write_in <= 1'b0;
		if (n >= 50) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(rd, e);
	endtask
	// Polling is bounded so a stuck flag ends the run
	task automatic poll(input logic [5:0] a, input logic [7:0] m);
		int k;
		k = 0;
		do begin
			bus(1'b0, a, 8'h00);
			k++;
		end while ((rd & m) === 8'h00 && k < 300);
		if (k >= 300) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic wait_words(input logic [7:0] n);
		int k;
		k = 0;
		while (gcnt !== n && k < 3000) begin
			@(posedge clk_in);
			k++;
		end
		if (k >= 3000) begin
			fail_count++;
			end_of_test();
		end
	endtask
	initial begin
		repeat (10) @(posedge clk_in);
		reset_n_in <= 1'b1;
		// Reset values, read-only bits and an unmapped place
		rdc(OFS_FLAGS, 8'h10);
		wr(OFS_FLAGS, 8'h00);
		rdc(OFS_FLAGS, 8'h10);
		wr(OFS_TX_STAT, 8'h00);
		rdc(OFS_TX_STAT, 8'h02);
		rdc(6'h2C, 8'h00);
		wr(OFS_PRIORITY, 8'hA5);
		rdc(OFS_PRIORITY, 8'hA5);
		// Half-bit of four clocks gives the 80 ns link bit
		wr(OFS_DIV_LO, 8'h03);
		wr(OFS_DIV_HI, 8'h00);
		wr(OFS_RX_STAT, 8'h80);
		wr(OFS_TX_STAT, 8'hB0);
		wr(OFS_ENABLES, 8'h10);
		repeat (3) @(posedge clk_in);
		check(irq_request_out, 1'b0);
		wr(OFS_IRQ_CTL, 8'hC0);
		repeat (3) @(posedge clk_in);
		check(irq_request_out, 1'b1);
		// Back-to-back words: second waits for the first to finish
		wr(OFS_TX_HOLD, 8'hA5);
		wr(OFS_TX_HOLD, 8'h3C);
		rdc(OFS_FLAGS, 8'h00);
		rdc(OFS_TX_STAT, 8'hB0);
		check(irq_request_out, 1'b0);
		wait_words(8'h01);
		check(got, 9'h0A5);
		repeat (2) @(posedge clk_in); // Handover lags the slave's count
		rdc(OFS_FLAGS, 8'h10);
		wait_words(8'h02);
		check(got, 9'h03C);
		poll(OFS_TX_STAT, 8'h02);
		rdc(OFS_TX_STAT, 8'hB2);
		// Nine-bit word carries the ninth bit last
		wr(OFS_TX_STAT, 8'hF1);
		mnine <= 1'b1;
		wr(OFS_TX_HOLD, 8'h5A);
		wait_words(8'h03);
		check(got, 9'h15A);
		poll(OFS_TX_STAT, 8'h02);
		mnine <= 1'b0;
		// Both lines inverted
		wr(OFS_TX_STAT, 8'hB0);
		wr(OFS_BAUD_CTL, 8'h30);
		repeat (3) @(posedge clk_in);
		mpol  <= 1'b1;
		mdpol <= 1'b1;
		check(shift_clock_line_out, 1'b1);
		check(serial_data_line_out, 1'b1);
		wr(OFS_TX_HOLD, 8'h0F);
		wait_words(8'h04);
		check(got, 9'h00F);
		poll(OFS_TX_STAT, 8'h02);
		wr(OFS_BAUD_CTL, 8'h00);
		repeat (3) @(posedge clk_in);
		mpol  <= 1'b0;
		mdpol <= 1'b0;
		// Single receive: one word, then the enable drops
		wr(OFS_TX_STAT, 8'h90);
		mword <= 9'h096;
		wr(OFS_ENABLES, 8'h20);
		wr(OFS_RX_STAT, 8'hA0);
		poll(OFS_FLAGS, 8'h20);
		check(irq_request_out, 1'b1);
		rdc(OFS_RX_STAT, 8'h80);
		rdc(OFS_RX_BUF, 8'h96);
		rdc(OFS_FLAGS, 8'h10);
		rd = gcnt;
		repeat (200) @(posedge clk_in);
		check(gcnt, rd);
		// Both enables: continuous wins, then overrun and its clear
		mword <= 9'h05C;
		wr(OFS_RX_STAT, 8'hB0);
		repeat (2) begin
			poll(OFS_FLAGS, 8'h20);
			rdc(OFS_RX_BUF, 8'h5C);
		end
		rdc(OFS_RX_STAT, 8'hB0);
		wait_words(gcnt + 8'h02);
		rdc(OFS_RX_STAT, 8'hB2);
		wr(OFS_RX_STAT, 8'h80);
		rdc(OFS_RX_STAT, 8'h80);
		rdc(OFS_RX_BUF, 8'h5C);
		repeat (2) @(posedge clk_in);
		mclr <= 1'b1;
		@(posedge clk_in);
		mclr <= 1'b0;
		// Nine-bit single receive: status first, then data
		mword <= 9'h1C3;
		mnine <= 1'b1;
		wr(OFS_RX_STAT, 8'hE0);
		poll(OFS_FLAGS, 8'h20);
		rdc(OFS_RX_STAT, 8'hC1);
		rdc(OFS_RX_BUF, 8'hC3);
		end_of_test();
	end
endmodule // ssm_master_tb_top
bind ssm_master ssm_master_monitor u_mon (
	.clk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
	.irq_request_out, .shift_clock_line_out, .shift_clock_line_oe_out,
	.serial_data_line_out, .serial_data_line_oe_out
);
